/* src/flag_pkg.sv */
package flag_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADR_W-1:0] OFS_INT_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] OFS_INT_MASK = 8'h08;
  localparam logic [ADR_W-1:0] OFS_TRANSMIT = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_RECEIVE = 8'h10;
  // ==========================================
  // bus_status field positions
  localparam int STATUS_W = 16;
  localparam int BIT_COLLISION = 10;
  localparam int BIT_GENERAL_CALL = 9;
  localparam int BIT_TEN_BIT = 8;
  localparam int BIT_WRITE_COLLISION = 7;
  localparam int BIT_OVERFLOW = 6;
  localparam int BIT_DATA_NOT_ADDR = 5;
  localparam int BIT_RECEIVE_FULL = 1;
  localparam int BIT_TRANSMIT_FULL = 0;
  // ==========================================
  // interrupt event positions
  localparam int EVENT_N = 6;
  localparam int EV_COLLISION = 0;
  localparam int EV_GENERAL_CALL = 1;
  localparam int EV_TEN_BIT = 2;
  localparam int EV_WRITE_COLLISION = 3;
  localparam int EV_OVERFLOW = 4;
  localparam int EV_RECEIVE_FULL = 5;
  // ==========================================
  // reset values
  localparam logic FLAG_RESET = 1'b0;
  localparam logic DATA_NOT_ADDR_RESET = 1'b0;
  localparam logic [EVENT_N-1:0] MASK_RESET = 6'h00;
  localparam int BYTE_W = 8;
endpackage

/* src/sticky_flag.sv */
`timescale 1ns/1ns
module sticky_flag
  import flag_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic flag_q
);
  // ==========================================
  // set wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_q <= FLAG_RESET;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule

/* src/event_irq.sv */
`timescale 1ns/1ns
module event_irq
  import flag_pkg::*;
#(
  parameter int N = EVENT_N
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // events and software access
  input wire logic [N-1:0] event_set,
  input wire logic read_clear,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_wdata,
  // state
  output logic [N-1:0] status_q,
  output logic [N-1:0] mask_q,
  output logic irq
);
  if (N < 1 || N > BYTE_W) begin : g_bad_n
    $error("event_irq: N must be 1..8");
  end
  // ==========================================
  // sticky status, cleared by read, set wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~{N{read_clear}}) | event_set;
    end
  end
  // ==========================================
  // mask
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_q <= MASK_RESET[N-1:0];
    end else if (mask_we) begin
      mask_q <= mask_wdata;
    end
  end
  assign irq = |(status_q & mask_q);
endmodule

/* src/bus_status_flags.sv */
`timescale 1ns/1ns
// Function
// - master collision sets master collision flag
// - general call sets flag; stop clears
// - second ten-bit byte match sets; stop clears
// - busy transmit write rejected, sets write collision
// - rejected write leaves transmit buffer unchanged
// - overflow set on attempted move when full
// - overflow means unread byte; software clears
// - slave address match clears data-not-address
// - slave transmit end or data sets it
// - receive full set on load, read clears
module bus_status_flags
  import flag_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // bus state and address match
  input wire logic master_mode,
  input wire logic slave_mode,
  input wire logic collision_detect,
  input wire logic stop_detect,
  input wire logic general_call_match,
  input wire logic ten_bit_second_match,
  input wire logic slave_address_match,
  input wire logic slave_data_received,
  input wire logic transmit_done,
  input wire logic port_busy,
  // receive shift register
  input wire logic receive_ready,
  input wire logic [BYTE_W-1:0] receive_shift_register,
  // transmit side
  output logic [BYTE_W-1:0] transmit_buffer,
  output logic transmit_load,
  // interrupt
  output logic irq
);
  // ==========================================
  // bus decode
  logic ack_q;
  logic req;
  logic wr_take;
  logic rd_take;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic master_collision_flag;
  logic general_call_flag;
  logic ten_bit_match_flag;
  logic write_collision_flag;
  logic receive_overflow_flag;
  logic receive_full_flag;
  logic transmit_full_q;
  logic data_not_address_q;
  logic [BYTE_W-1:0] receive_buffer_q;
  logic [STATUS_W-1:0] bus_status;
  logic [EVENT_N-1:0] int_status;
  logic [EVENT_N-1:0] int_mask;
  logic [EVENT_N-1:0] events;
  logic wr_status_lo;
  logic wr_status_hi;
  logic tx_write;
  logic tx_reject;
  logic rx_read;
  logic rx_move;
  logic overflow_set;

  assign req = wb_cyc_i && wb_stb_i;
  // writes apply at the ack edge; read clears at the latch edge,
  // so an event landing between latch and ack is not lost
  assign wr_take = req && ack_q && wb_we_i;
  assign rd_take = req && !ack_q && !wb_we_i;
  assign wr_status_lo = wr_take && wb_adr_i == OFS_STATUS && wb_sel_i[0];
  assign wr_status_hi = wr_take && wb_adr_i == OFS_STATUS && wb_sel_i[1];
  assign tx_write = wr_take && wb_adr_i == OFS_TRANSMIT && wb_sel_i[0];
  assign rx_read = rd_take && wb_adr_i == OFS_RECEIVE;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  // ==========================================
  // read mux, unmapped reads as zero
  always_comb begin
    rdata_d = '0;
    unique case (wb_adr_i)
      OFS_STATUS: rdata_d[STATUS_W-1:0] = bus_status;
      OFS_INT_STATUS: rdata_d[EVENT_N-1:0] = int_status;
      OFS_INT_MASK: rdata_d[EVENT_N-1:0] = int_mask;
      OFS_TRANSMIT: rdata_d[BYTE_W-1:0] = transmit_buffer;
      OFS_RECEIVE: rdata_d[BYTE_W-1:0] = receive_buffer_q;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (req && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end
  assign wb_dat_o = rdata_q;

  // ==========================================
  // collision and address flags
  sticky_flag u_collision (
    .mclk(mclk),
    .rst(rst),
    .set(master_mode && collision_detect),
    .clr(wr_status_hi && !wb_dat_i[BIT_COLLISION]),
    .flag_q(master_collision_flag)
  );

  sticky_flag u_general_call (
    .mclk(mclk),
    .rst(rst),
    .set(general_call_match),
    .clr(stop_detect),
    .flag_q(general_call_flag)
  );

  sticky_flag u_ten_bit (
    .mclk(mclk),
    .rst(rst),
    .set(ten_bit_second_match),
    .clr(stop_detect),
    .flag_q(ten_bit_match_flag)
  );

  // ==========================================
  // transmit buffer and write collision
  assign tx_reject = tx_write && (port_busy || transmit_full_q);

  sticky_flag u_write_collision (
    .mclk(mclk),
    .rst(rst),
    .set(tx_reject),
    .clr(wr_status_lo && !wb_dat_i[BIT_WRITE_COLLISION]),
    .flag_q(write_collision_flag)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      transmit_buffer <= '0;
      transmit_load <= 1'b0;
    end else begin
      transmit_load <= tx_write && !tx_reject;
      if (tx_write && !tx_reject) begin
        transmit_buffer <= wb_dat_i[BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      transmit_full_q <= 1'b0;
    end else if (tx_write && !tx_reject) begin
      transmit_full_q <= 1'b1;
    end else if (transmit_done) begin
      transmit_full_q <= 1'b0;
    end
  end

  // ==========================================
  // receive buffer, full and overflow
  assign overflow_set = receive_ready && receive_full_flag;
  assign rx_move = receive_ready && !receive_full_flag;

  sticky_flag u_overflow (
    .mclk(mclk),
    .rst(rst),
    .set(overflow_set),
    .clr(wr_status_lo && !wb_dat_i[BIT_OVERFLOW]),
    .flag_q(receive_overflow_flag)
  );

  sticky_flag u_receive_full (
    .mclk(mclk),
    .rst(rst),
    .set(rx_move),
    .clr(rx_read),
    .flag_q(receive_full_flag)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      receive_buffer_q <= '0;
    end else if (rx_move) begin
      receive_buffer_q <= receive_shift_register;
    end
  end

  // ==========================================
  // data-not-address, address match wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_not_address_q <= DATA_NOT_ADDR_RESET;
    end else if (slave_mode && slave_address_match) begin
      data_not_address_q <= 1'b0;
    end else if (slave_mode && (transmit_done || slave_data_received)) begin
      data_not_address_q <= 1'b1;
    end
  end

  // ==========================================
  // status word and interrupt
  always_comb begin
    bus_status = '0;
    bus_status[BIT_COLLISION] = master_collision_flag;
    bus_status[BIT_GENERAL_CALL] = general_call_flag;
    bus_status[BIT_TEN_BIT] = ten_bit_match_flag;
    bus_status[BIT_WRITE_COLLISION] = write_collision_flag;
    bus_status[BIT_OVERFLOW] = receive_overflow_flag;
    bus_status[BIT_DATA_NOT_ADDR] = data_not_address_q;
    bus_status[BIT_RECEIVE_FULL] = receive_full_flag;
    bus_status[BIT_TRANSMIT_FULL] = transmit_full_q;
  end

  always_comb begin
    events = '0;
    events[EV_COLLISION] = master_mode && collision_detect;
    events[EV_GENERAL_CALL] = general_call_match;
    events[EV_TEN_BIT] = ten_bit_second_match;
    events[EV_WRITE_COLLISION] = tx_reject;
    events[EV_OVERFLOW] = overflow_set;
    events[EV_RECEIVE_FULL] = rx_move;
  end

  event_irq #(
    .N(EVENT_N)
  ) u_irq (
    .mclk(mclk),
    .rst(rst),
    .event_set(events),
    .read_clear(rd_take && wb_adr_i == OFS_INT_STATUS),
    .mask_we(wr_take && wb_adr_i == OFS_INT_MASK && wb_sel_i[0]),
    .mask_wdata(wb_dat_i[EVENT_N-1:0]),
    .status_q(int_status),
    .mask_q(int_mask),
    .irq(irq)
  );

  // ==========================================
  // checks
  sequence busy_tx_write_s;
    tx_write && (port_busy || transmit_full_q);
  endsequence

  sequence status_hi_zero_s;
    wr_status_hi && !wb_dat_i[BIT_COLLISION];
  endsequence

  AST_ACK_ONE: assert property (@(posedge mclk) disable iff (rst)
    req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("ack not a single cycle pulse");

  AST_COLLISION_SET: assert property (@(posedge mclk) disable iff (rst)
    master_mode && collision_detect |=> master_collision_flag)
    else $error("collision flag not set");

  AST_COLLISION_HOLD: assert property (@(posedge mclk) disable iff (rst)
    master_collision_flag && !(wr_status_hi && !wb_dat_i[BIT_COLLISION]) |=>
    master_collision_flag)
    else $error("collision flag lost without a zero write");

  AST_COLLISION_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    status_hi_zero_s ##0 !(master_mode && collision_detect) |=> !master_collision_flag)
    else $error("collision flag not cleared by a zero write");

  AST_GENERAL_CALL: assert property (@(posedge mclk) disable iff (rst)
    stop_detect && !general_call_match |=> !general_call_flag)
    else $error("general call flag not cleared at stop");

  AST_TEN_BIT: assert property (@(posedge mclk) disable iff (rst)
    ten_bit_second_match |=> ten_bit_match_flag ##1
    (ten_bit_match_flag || $past(stop_detect)))
    else $error("ten bit flag wrong");

  AST_WRITE_REJECT: assert property (@(posedge mclk) disable iff (rst)
    busy_tx_write_s |=> write_collision_flag && !transmit_load)
    else $error("busy write not rejected");

  AST_BUFFER_KEPT: assert property (@(posedge mclk) disable iff (rst)
    busy_tx_write_s |=> $stable(transmit_buffer))
    else $error("rejected write changed transmit buffer");

  AST_OVERFLOW: assert property (@(posedge mclk) disable iff (rst)
    receive_ready && receive_full_flag |=>
    receive_overflow_flag && $stable(receive_buffer_q))
    else $error("overflow not flagged or buffer overwritten");

  AST_RECEIVE_FULL: assert property (@(posedge mclk) disable iff (rst)
    receive_ready && !receive_full_flag |=>
    receive_full_flag && receive_buffer_q == $past(receive_shift_register))
    else $error("receive buffer not loaded");

  AST_RECEIVE_READ: assert property (@(posedge mclk) disable iff (rst)
    rx_read && !receive_ready |=> !receive_full_flag)
    else $error("read did not clear receive full");

  AST_ADDRESS_MATCH: assert property (@(posedge mclk) disable iff (rst)
    slave_mode && slave_address_match |=> !data_not_address_q)
    else $error("data-not-address not cleared");

  AST_DATA_BYTE: assert property (@(posedge mclk) disable iff (rst)
    slave_mode && !slave_address_match && slave_data_received |=> data_not_address_q)
    else $error("data-not-address not set");

  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (rst)
    overflow_set && int_mask[EV_OVERFLOW] &&
    !(wr_take && wb_adr_i == OFS_INT_MASK) |=> irq)
    else $error("masked-in event did not raise irq");
endmodule

/* tb/bus_peer_model.sv */
`timescale 1ns/1ns
// ==========================================
// serial bus peers: one event pulse per request
module bus_peer_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request from bench
  input wire logic fire,
  input wire logic [2:0] kind,
  input wire logic [7:0] byte_in,
  // bus events
  output logic [7:0] pulse,
  output logic [7:0] rx_byte
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse <= 8'h00;
      rx_byte <= 8'h00;
    end else begin
      pulse <= fire ? (8'h01 << kind) : 8'h00;
      // byte only valid with the pulse, garbage otherwise
      rx_byte <= fire ? byte_in : ~rx_byte;
    end
  end
endmodule

/* tb/bus_status_flags_tb.sv */
`timescale 1ns/1ns
module bus_status_flags_tb;
  import flag_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h3;
  logic [31:0] dat = 32'h0, q, wb_dat_o;
  logic wb_ack_o, irq, transmit_load;
  logic master_mode = 1'b1, slave_mode = 1'b1, port_busy = 1'b0;
  logic fire = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [7:0] rxb = 8'h00, pulse, rx_byte, transmit_buffer;
  int error_cnt = 0, n_tests = 0, loads = 0, cyc_cnt = 0;
  // kind, byte, expected status
  logic [27:0] rows [9] = '{28'h0000400, 28'h2000600, 28'h3000700, 28'h1000400,
    28'h5000420, 28'h4000400, 28'h6000420, 28'h73c0422, 28'h7c30462};

  initial begin
    forever #10 mclk = ~mclk;
  end

  bus_peer_model peer (.mclk(mclk), .rst(rst), .fire(fire), .kind(kind), .byte_in(rxb),
    .pulse(pulse), .rx_byte(rx_byte));

  bus_status_flags DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .master_mode(master_mode), .slave_mode(slave_mode),
    .collision_detect(pulse[0]), .stop_detect(pulse[1]), .general_call_match(pulse[2]),
    .ten_bit_second_match(pulse[3]), .slave_address_match(pulse[4]),
    .slave_data_received(pulse[5]), .transmit_done(pulse[6]), .port_busy(port_busy),
    .receive_ready(pulse[7]), .receive_shift_register(rx_byte),
    .transmit_buffer(transmit_buffer), .transmit_load(transmit_load), .irq(irq));

  always @(posedge mclk) begin
    if (transmit_load === 1'b1) loads <= loads + 1;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ==========================================
  // shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= we;
    adr <= a;
    dat <= d;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    wwe <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic ev(input logic [2:0] k, input logic [7:0] b);
    @(posedge mclk);
    fire <= 1'b1;
    kind <= k;
    rxb <= b;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic st(input logic [31:0] exp);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("status", q & 32'h07e3, exp);
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    chk("irq reset", {31'h0, irq}, 32'h0);
    st(32'h0);
    wb(1'b0, OFS_INT_MASK, 32'h0);
    chk("mask reset", q, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      ev(rows[i][26:24], rows[i][23:16]);
      st({16'h0, rows[i][15:0]});
    end
    $display("test table done");
    wb(1'b0, OFS_RECEIVE, 32'h0);
    chk("receive", q, 32'h3c);
    st(32'h460);
    wb(1'b1, OFS_STATUS, 32'hffff);
    st(32'h460);
    wb(1'b1, OFS_STATUS, 32'h0);
    st(32'h020);
    $display("test clear done");
    port_busy <= 1'b1;
    wb(1'b1, OFS_TRANSMIT, 32'h5a);
    repeat (2) @(posedge mclk);
    chk("loads busy", loads, 32'h0);
    st(32'h0a0);
    port_busy <= 1'b0;
    wb(1'b1, OFS_TRANSMIT, 32'ha5);
    repeat (2) @(posedge mclk);
    chk("loads", loads, 32'h1);
    chk("tx buffer", {24'h0, transmit_buffer}, 32'ha5);
    st(32'h0a1);
    ev(3'h6, 8'h00);
    st(32'h0a0);
    wb(1'b1, OFS_STATUS, 32'h0);
    st(32'h020);
    $display("test transmit done");
    wb(1'b1, OFS_INT_MASK, 32'h3f);
    chk("irq on", {31'h0, irq}, 32'h1);
    wb(1'b0, OFS_INT_STATUS, 32'h0);
    chk("int status", q, 32'h3f);
    chk("irq off", {31'h0, irq}, 32'h0);
    wb(1'b1, OFS_INT_MASK, 32'h01);
    ev(3'h2, 8'h00);
    chk("irq masked", {31'h0, irq}, 32'h0);
    ev(3'h0, 8'h00);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, OFS_INT_MASK, 32'h10);
    ev(3'h7, 8'h11);
    chk("irq load masked", {31'h0, irq}, 32'h0);
    ev(3'h7, 8'h22);
    chk("irq overflow", {31'h0, irq}, 32'h1);
    wb(1'b0, OFS_RECEIVE, 32'h0);
    chk("receive kept", q, 32'h11);
    $display("test interrupt done");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    st(32'h0);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    master_mode <= 1'b0;
    slave_mode <= 1'b0;
    ev(3'h0, 8'h00);
    ev(3'h5, 8'h00);
    st(32'h0);
    $display("test reset and mode done");
    end_sim();
  end
endmodule
